// ===== core/zone_security_status_bank.sv
// zone one security status bank plus zone two offset decode
// assumes otp read events and cpu strobes on mclk; scan pins come from outside
//
// What this block does
// [R1] ram exec-protect bits 7..0 captured from otp word when that word is read
// [R2] bit 0 means exec-only on, 1 off, only for sections in zone one
// [R3] debug unlock words loaded only by scan chain; software reads only
// [R4] scanned unlock key compared to hidden password filled by otp dummy read
// [R5] debug unlock words cleared only by power-on reset, not system reset
// [R6] boot auth key words loaded from otp on read, cleared on system reset
// [R7] software leaves unlisted zone two offsets alone
// [R8] zone two offsets decoded as listed map
// [R9] cpu writes ignored; reads never change stored contents
`timescale 1ns/1ps

module zone_security_status_bank
    import zone_status_pkg::*;
(
    // clock and resets
    input  wire logic                     mclk,
    input  wire logic                     rst_b,
    input  wire logic                     power_on_reset_n,
    // register port
    input  wire logic [7:0]               reg_addr,
    input  wire logic [31:0]              reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic [31:0]                   reg_rdata,
    output logic                          z2_sel,
    // otp read events
    input  wire otp_read_t                otp_rd,
    // debug scan chain pins
    input  wire scan_in_t                 scan_pins,
    output logic                          scan_tdo,
    // zone ownership and protection outputs
    input  wire logic [RAM_SECTIONS-1:0]  ram_in_zone1,
    output logic [RAM_SECTIONS-1:0]       ram_exec_only,
    output logic                          debug_key_match
);

    // ****************************************************************
    // scan pin synchronisers
    // ****************************************************************
    scan_in_t scan_s1_r;
    scan_in_t scan_s2_r;
    scan_in_t scan_s3_r;

    // two flops then an edge history stage
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            scan_s1_r <= '0;
            scan_s2_r <= '0;
            scan_s3_r <= '0;
        end else begin
            scan_s1_r <= scan_pins;
            scan_s2_r <= scan_s1_r;
            scan_s3_r <= scan_s2_r;
        end
    end

    logic shift_pulse;
    logic update_pulse;
    assign shift_pulse  = scan_s2_r.shift & ~scan_s3_r.shift;
    assign update_pulse = scan_s2_r.update & ~scan_s3_r.update;

    // ****************************************************************
    // debug unlock key: scan shift register and four words
    // ****************************************************************
    localparam int CHAIN_W = KEY_WORDS * WORD_W;

    logic [CHAIN_W-1:0]  chain_r;
    logic [CHAIN_W-1:0]  chain_nxt;
    logic [WORD_W-1:0]   dbg_key_r   [KEY_WORDS];
    logic [WORD_W-1:0]   dbg_key_nxt [KEY_WORDS];

    // shift on each shift edge, word a at the low end
    always_comb begin
        chain_nxt = chain_r;
        if (shift_pulse) begin
            chain_nxt = {scan_s2_r.tdi, chain_r[CHAIN_W-1:1]}; // R3
        end
    end

    // only the update edge moves the chain into the key words; cpu has no path
    always_comb begin
        for (int i = 0; i < KEY_WORDS; i++) begin
            dbg_key_nxt[i] = dbg_key_r[i];
            if (update_pulse) begin
                dbg_key_nxt[i] = chain_r[i*WORD_W +: WORD_W]; // R3
            end
        end
    end

    // power-on reset domain only
    always_ff @(posedge mclk or negedge power_on_reset_n) begin
        if (!power_on_reset_n) begin
            chain_r <= '0;
            for (int i = 0; i < KEY_WORDS; i++) begin
                dbg_key_r[i] <= KEY_RESET; // R5
            end
        end else begin
            chain_r <= chain_nxt;
            for (int i = 0; i < KEY_WORDS; i++) begin
                dbg_key_r[i] <= dbg_key_nxt[i];
            end
        end
    end

    // ****************************************************************
    // otp captures: ram exec bits, boot auth key, hidden password
    // ****************************************************************
    logic [RAM_SECTIONS-1:0]  ram_exec_r;
    logic [RAM_SECTIONS-1:0]  ram_exec_nxt;
    logic [WORD_W-1:0]        auth_key_r   [KEY_WORDS];
    logic [WORD_W-1:0]        auth_key_nxt [KEY_WORDS];
    logic [WORD_W-1:0]        pswd_r       [KEY_WORDS];
    logic [WORD_W-1:0]        pswd_nxt     [KEY_WORDS];
    logic                     match_nxt;

    always_comb begin
        ram_exec_nxt = ram_exec_r;
        if (otp_rd.valid && otp_rd.sel == OTP_RAM_EXEC) begin
            ram_exec_nxt = otp_rd.data[RAM_SECTIONS-1:0]; // R1
        end
        for (int i = 0; i < KEY_WORDS; i++) begin
            auth_key_nxt[i] = auth_key_r[i];
            pswd_nxt[i]     = pswd_r[i];
            if (otp_rd.valid && otp_rd.word == 2'(i)) begin
                if (otp_rd.sel == OTP_AUTH_KEY) begin
                    auth_key_nxt[i] = otp_rd.data; // R6
                end
                if (otp_rd.sel == OTP_DBG_PSWD) begin
                    pswd_nxt[i] = otp_rd.data; // R4
                end
            end
        end
    end

    // key matches the hidden password word for word
    always_comb begin
        match_nxt = 1'b1;
        for (int i = 0; i < KEY_WORDS; i++) begin
            if (dbg_key_r[i] != pswd_r[i]) begin
                match_nxt = 1'b0; // R4
            end
        end
    end

    // system reset domain
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ram_exec_r <= RAM_EXEC_RESET;
            for (int i = 0; i < KEY_WORDS; i++) begin
                auth_key_r[i] <= KEY_RESET; // R6
                pswd_r[i]     <= KEY_RESET;
            end
        end else begin
            ram_exec_r <= ram_exec_nxt;
            for (int i = 0; i < KEY_WORDS; i++) begin
                auth_key_r[i] <= auth_key_nxt[i];
                pswd_r[i]     <= pswd_nxt[i];
            end
        end
    end

    // ****************************************************************
    // protection outputs
    // ****************************************************************
    logic [RAM_SECTIONS-1:0] exec_only_nxt;

    // status 0 enables execute-only, only for zone one sections
    always_comb begin
        exec_only_nxt = ~ram_exec_r & ram_in_zone1; // R2
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ram_exec_only   <= '0;
            debug_key_match <= 1'b0;
            scan_tdo        <= 1'b0;
        end else begin
            ram_exec_only   <= exec_only_nxt;
            debug_key_match <= match_nxt;
            scan_tdo        <= chain_r[0];
        end
    end

    // ****************************************************************
    // register read decode
    // ****************************************************************
    logic [31:0] rdata_nxt;
    logic        z2_nxt;

    // reads are pure selects; writes land nowhere
    always_comb begin
        rdata_nxt = READ_ZERO; // R9
        if (reg_rd) begin
            if (reg_addr == OFF_RAM_EXEC) begin
                rdata_nxt = {24'h000000, ram_exec_r};
            end else if (reg_addr == OFF_DBG_KEY_A) begin
                rdata_nxt = dbg_key_r[0]; // R3
            end else if (reg_addr == OFF_DBG_KEY_B) begin
                rdata_nxt = dbg_key_r[1];
            end else if (reg_addr == OFF_DBG_KEY_C) begin
                rdata_nxt = dbg_key_r[2];
            end else if (reg_addr == OFF_DBG_KEY_D) begin
                rdata_nxt = dbg_key_r[3];
            end else if (reg_addr == OFF_AUTH_KEY_A) begin
                rdata_nxt = auth_key_r[0];
            end else if (reg_addr == OFF_AUTH_KEY_B) begin
                rdata_nxt = auth_key_r[1];
            end else if (reg_addr == OFF_AUTH_KEY_C) begin
                rdata_nxt = auth_key_r[2];
            end else if (reg_addr == OFF_AUTH_KEY_D) begin
                rdata_nxt = auth_key_r[3];
            end
        end
    end

    // zone two map: flags an access that falls on a listed even offset
    always_comb begin
        z2_nxt = 1'b0;
        if ((reg_rd || reg_wr) && !reg_addr[0]) begin
            if (reg_addr == Z2_LINK_PTR || reg_addr == Z2_OTP_LOCK || reg_addr == Z2_LINK_ERR) begin
                z2_nxt = 1'b1; // R8
            end else if (reg_addr >= Z2_GP_FIRST && reg_addr <= Z2_GP_LAST) begin
                z2_nxt = 1'b1;
            end else if (reg_addr >= Z2_KEY_FIRST && reg_addr <= Z2_KEY_LAST) begin
                z2_nxt = 1'b1;
            end else if (reg_addr == Z2_CTRL) begin
                z2_nxt = 1'b1;
            end else if (reg_addr >= Z2_GRAB_FIRST && reg_addr <= Z2_GRAB_LAST) begin
                z2_nxt = 1'b1;
            end else if (reg_addr >= Z2_EXEC_FIRST && reg_addr <= Z2_EXEC_LAST) begin
                z2_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= READ_ZERO;
            z2_sel    <= 1'b0;
        end else begin
            reg_rdata <= rdata_nxt;
            z2_sel    <= z2_nxt;
        end
    end

endmodule

// ===== inc/zone_status_pkg.sv
// package for the zone security status bank: register indices, field layout, reset values
// assumes a plain register port with word indices as printed and 32-bit data
package zone_status_pkg;

    // ****************************************************************
    // zone one status bank offsets (printed indices)
    // ****************************************************************
    localparam logic [7:0] OFF_RAM_EXEC      = 8'h2A;
    localparam logic [7:0] OFF_DBG_KEY_A     = 8'h2E;
    localparam logic [7:0] OFF_DBG_KEY_B     = 8'h30;
    localparam logic [7:0] OFF_DBG_KEY_C     = 8'h32;
    localparam logic [7:0] OFF_DBG_KEY_D     = 8'h34;
    localparam logic [7:0] OFF_AUTH_KEY_A    = 8'h36;
    localparam logic [7:0] OFF_AUTH_KEY_B    = 8'h38;
    localparam logic [7:0] OFF_AUTH_KEY_C    = 8'h3A;
    localparam logic [7:0] OFF_AUTH_KEY_D    = 8'h3C;
    localparam logic [7:0] OFF_KEY_STEP      = 8'h02;

    // ****************************************************************
    // zone two bank offsets (map only)
    // ****************************************************************
    localparam logic [7:0] Z2_LINK_PTR       = 8'h00;
    localparam logic [7:0] Z2_OTP_LOCK       = 8'h02;
    localparam logic [7:0] Z2_LINK_ERR       = 8'h06;
    localparam logic [7:0] Z2_GP_FIRST       = 8'h08;
    localparam logic [7:0] Z2_GP_LAST        = 8'h0E;
    localparam logic [7:0] Z2_KEY_FIRST      = 8'h10;
    localparam logic [7:0] Z2_KEY_LAST       = 8'h16;
    localparam logic [7:0] Z2_CTRL           = 8'h18;
    localparam logic [7:0] Z2_GRAB_FIRST     = 8'h1A;
    localparam logic [7:0] Z2_GRAB_LAST      = 8'h20;
    localparam logic [7:0] Z2_EXEC_FIRST     = 8'h26;
    localparam logic [7:0] Z2_EXEC_LAST      = 8'h2A;

    // ****************************************************************
    // field layout and reset values
    // ****************************************************************
    localparam int         RAM_SECTIONS      = 8;
    localparam int         KEY_WORDS         = 4;
    localparam int         WORD_W            = 32;
    localparam logic [7:0] RAM_EXEC_RESET    = 8'h00;
    localparam logic [31:0] KEY_RESET        = 32'h0000_0000;
    localparam logic [31:0] Z2_LINK_RESET    = 32'hFFFF_C000;
    localparam logic [31:0] Z2_LOCK_RESET    = 32'h0000_0001;
    localparam logic [31:0] READ_ZERO        = 32'h0000_0000;

    // otp read event: which location was read, and the word that came back
    typedef enum logic [2:0] {
        OTP_NONE     = 3'b000,
        OTP_RAM_EXEC = 3'b001,
        OTP_AUTH_KEY = 3'b011,
        OTP_DBG_PSWD = 3'b010
    } otp_sel_t;

    typedef struct packed {
        logic           valid;
        otp_sel_t       sel;
        logic [1:0]     word;
        logic [31:0]    data;
    } otp_read_t;

    // debug scan chain pins: shift, update, tdi
    typedef struct packed {
        logic           shift;
        logic           update;
        logic           tdi;
    } scan_in_t;

endpackage

// ===== tb/zone_status_checker.sv
// checker for the zone status bank: register port, otp capture, zone two decode
// assumes one clock mclk and the async active-low rst_b of the top module
`timescale 1ns/1ps
module zone_status_checker
    import zone_status_pkg::*;
(
    // clock and reset
    input wire logic                    mclk,
    input wire logic                    rst_b,
    // register port
    input wire logic [7:0]              reg_addr,
    input wire logic                    reg_wr,
    input wire logic                    reg_rd,
    input wire logic [31:0]             reg_rdata,
    input wire logic                    z2_sel,
    // otp events and zone outputs
    input wire otp_read_t               otp_rd,
    input wire logic [RAM_SECTIONS-1:0] ram_in_zone1,
    input wire logic [RAM_SECTIONS-1:0] ram_exec_only
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // listed zone two offsets and mapped zone one offsets
    function automatic logic z2_hit(logic [7:0] a);
        return !a[0] && a <= 8'h2A && a != 8'h04 && a != 8'h22 && a != 8'h24;
    endfunction
    function automatic logic z1_hit(logic [7:0] a);
        return a == OFF_RAM_EXEC || (!a[0] && a >= OFF_DBG_KEY_A && a <= OFF_AUTH_KEY_D);
    endfunction
    // otp capture of the exec word, and a cycle with nothing moving
    sequence exec_ev;
        otp_rd.valid && otp_rd.sel == OTP_RAM_EXEC;
    endsequence
    sequence quiet_ev;
        !otp_rd.valid && $stable(ram_in_zone1);
    endsequence
    chk_rdata_only_read: assert property (reg_rdata != READ_ZERO |-> $past(reg_rd))
        else $error("read data outside the answer cycle");
    chk_z2_decode: assert property ((reg_rd || reg_wr) |=> z2_sel == z2_hit($past(reg_addr)))
        else $error("zone two select wrong");
    chk_z2_quiet: assert property (!(reg_rd || reg_wr) |=> !z2_sel)
        else $error("zone two select without strobe");
    chk_unmapped_zero: assert property (reg_rd && !z1_hit(reg_addr) |=> reg_rdata == READ_ZERO)
        else $error("unmapped read not zero");
    chk_exec_upper: assert property (reg_rd && reg_addr == OFF_RAM_EXEC |=> reg_rdata[31:8] == 24'h0)
        else $error("exec status upper bits set");
    chk_exec_capture: assert property (exec_ev ##1 quiet_ev |=>
        ram_exec_only == (~$past(otp_rd.data[7:0], 2) & $past(ram_in_zone1)))
        else $error("exec protect not taken from otp word");
    chk_exec_zone: assert property ((ram_exec_only & ~$past(ram_in_zone1)) == 8'h00)
        else $error("exec protect outside zone one");
    chk_write_quiet: assert property (((reg_wr && !$past(otp_rd.valid)) and quiet_ev) ##1 quiet_ev
        |=> $stable(ram_exec_only))
        else $error("write changed exec protect");
endmodule
bind zone_security_status_bank zone_status_checker zone_status_checker_inst (.mclk(mclk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .z2_sel(z2_sel),
    .otp_rd(otp_rd), .ram_in_zone1(ram_in_zone1), .ram_exec_only(ram_exec_only));

// ===== tb/otp_debug_model.sv
// far side model: otp array read events and the debug probe scan pins
// assumes mclk of the bank; tasks are called from the bench
`timescale 1ns/1ps
module otp_debug_model
    import zone_status_pkg::*;
(
    // clock
    input wire logic mclk,
    // otp events and scan pins
    output otp_read_t otp_rd,
    output scan_in_t  scan_pins
);
    initial begin
        otp_rd = '0;
        scan_pins = '0;
    end
    // one-cycle otp event; word and data lines show the inverse afterwards, sel returns to OTP_NONE
    task automatic otp_read(input otp_sel_t sel, input logic [1:0] w, input logic [31:0] d);
        @(posedge mclk);
        otp_rd <= '{1'b1, sel, w, d};
        @(posedge mclk);
        otp_rd <= '{1'b0, OTP_NONE, ~w, ~d};
    endtask
    // debugger shifts the key lsb first from word a, then pulses update
    task automatic scan_key(input logic [127:0] k);
        for (int i = 0; i < 128; i++) begin
            scan_pins.tdi <= k[i];
            repeat (3) @(posedge mclk);
            scan_pins.shift <= 1'b1;
            repeat (3) @(posedge mclk);
            scan_pins.shift <= 1'b0;
        end
        repeat (3) @(posedge mclk);
        scan_pins.update <= 1'b1;
        repeat (3) @(posedge mclk);
        scan_pins.update <= 1'b0;
        repeat (6) @(posedge mclk);
    endtask
endmodule

// ===== tb/zone_security_status_bank_tb.sv
// self-checking bench of the zone security status bank
// assumes the otp and debug model drives the far side pins
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module zone_security_status_bank_tb;
    import zone_status_pkg::*;
    logic         mclk, rst_b, power_on_reset_n, reg_wr, reg_rd, z2_sel, scan_tdo, debug_key_match, rd_z;
    logic [7:0]   reg_addr, ram_in_zone1, ram_exec_only;
    logic [31:0]  reg_wdata, reg_rdata, rd_d;
    otp_read_t    otp_rd;
    scan_in_t     scan_pins;
    int           n_errors = 0;
    int           tests_run = 0;
    logic [127:0] pswd = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3211;
    zone_security_status_bank zone_security_status_bank_inst (.mclk(mclk), .rst_b(rst_b),
        .power_on_reset_n(power_on_reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .z2_sel(z2_sel), .otp_rd(otp_rd), .scan_pins(scan_pins),
        .scan_tdo(scan_tdo), .ram_in_zone1(ram_in_zone1), .ram_exec_only(ram_exec_only),
        .debug_key_match(debug_key_match));
    otp_debug_model otp_debug_model_inst (.mclk(mclk), .otp_rd(otp_rd), .scan_pins(scan_pins));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // one read cycle; data and select are taken in the answer cycle
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        rd_d = reg_rdata;
        rd_z = z2_sel;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    function automatic logic z2_exp(logic [7:0] a);
        return !a[0] && a <= 8'h2A && a != 8'h04 && a != 8'h22 && a != 8'h24;
    endfunction
    // indices 0x00 to 0x3F after reset: zero data, zone two decode
    task automatic t_map;
        for (int a = 0; a < 64; a++) begin
            rd(8'(a));
            `CHK("z2 select", z2_exp(8'(a)), rd_z)
            `CHK("reset value", 32'h0, rd_d)
        end
    endtask
    // otp capture of exec word and auth keys, then writes must not stick
    task automatic t_otp;
        otp_debug_model_inst.otp_read(OTP_RAM_EXEC, 2'd0, 32'hFFFF_FF5A);
        for (int w = 0; w < 4; w++) otp_debug_model_inst.otp_read(OTP_AUTH_KEY, 2'(w), 32'hC0DE_0000 + w);
        // writes go only to listed offsets; reserved zone two offsets are left alone
        wr(OFF_RAM_EXEC, 32'hFFFF_FFFF);
        for (int i = 0; i < 8; i++) wr(8'(OFF_DBG_KEY_A + 2 * i), 32'hFFFF_FFFF);
        rd(OFF_RAM_EXEC);
        `CHK("exec status", 32'h0000_005A, rd_d)
        `CHK("exec protect", 8'h05, ram_exec_only)
        for (int w = 0; w < 4; w++) begin
            rd(8'(OFF_AUTH_KEY_A + 2 * w));
            `CHK("auth key", 32'hC0DE_0000 + w, rd_d)
            rd(8'(OFF_DBG_KEY_A + 2 * w));
            `CHK("debug key unwritable", 32'h0, rd_d)
        end
        @(posedge mclk);
        ram_in_zone1 <= 8'hF0;
        repeat (3) @(posedge mclk);
        #1;
        `CHK("exec protect zone", 8'hA0, ram_exec_only)
    endtask
    // password dummy read, debugger scan, key compare
    task automatic t_scan;
        for (int w = 0; w < 4; w++) otp_debug_model_inst.otp_read(OTP_DBG_PSWD, 2'(w), pswd[32*w+:32]);
        repeat (4) @(posedge mclk);
        `CHK("match before scan", 1'b0, debug_key_match)
        otp_debug_model_inst.scan_key(pswd);
        for (int w = 0; w < 4; w++) begin
            rd(8'(OFF_DBG_KEY_A + 2 * w));
            `CHK("debug key", pswd[32*w+:32], rd_d)
        end
        `CHK("match after scan", 1'b1, debug_key_match)
        `CHK("scan out after scan", 1'b1, scan_tdo)
    endtask
    // system reset keeps debug keys; power-on reset clears them
    task automatic t_resets;
        @(posedge mclk);
        rst_b <= 1'b0;
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        rd(OFF_DBG_KEY_D);
        `CHK("debug key kept", pswd[127:96], rd_d)
        rd(OFF_AUTH_KEY_A);
        `CHK("auth key cleared", 32'h0, rd_d)
        `CHK("exec protect reset", 8'hF0, ram_exec_only)
        `CHK("match hidden cleared", 1'b0, debug_key_match)
        `CHK("scan chain kept", 1'b1, scan_tdo)
        @(posedge mclk);
        rst_b <= 1'b0;
        power_on_reset_n <= 1'b0;
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        power_on_reset_n <= 1'b1;
        rd(OFF_DBG_KEY_A);
        `CHK("debug key por", 32'h0, rd_d)
        `CHK("scan chain por", 1'b0, scan_tdo)
        repeat (3) @(posedge mclk);
        `CHK("match both zero", 1'b1, debug_key_match)
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #100000;
        n_errors++;
        summarize();
    end
    initial begin
        {rst_b, power_on_reset_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        ram_in_zone1 = 8'h0F;
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        power_on_reset_n <= 1'b1;
        t_map();
        t_otp();
        t_scan();
        t_resets();
        summarize();
    end
endmodule
